// ==== src/imac_acc.sv ====
`timescale 1ns/1ps
module imac_acc
    import imac_pkg::*;
(
    input  wire logic  i_clk,
    input  wire logic  i_rst_n,
    imac_acc_if.store  acc
);
    imac_acc_t s_ff;
    imac_acc_t nxt_s;
    logic [GUARD_W-1:0] ext8;
    logic [WORD_W-1:0]  ext16;
    logic               sgn;

    always_comb begin
        nxt_s = s_ff;
        sgn   = 1'b0;
        ext8  = '0;
        ext16 = '0;
        if (acc.pre_en) begin
            // RQ25: preload one field, treat the others
            sgn   = acc.pre_signed & ((acc.pre_field == PF_GUARD) ? acc.pre_data[GUARD_W-1] :
                                      acc.pre_data[WORD_W-1]);
            ext8  = {GUARD_W{sgn}};
            ext16 = {WORD_W{sgn}};
            // RQ23: guard, upper and lower fields
            unique case (acc.pre_field)
                PF_LOWER: begin
                    nxt_s.value[WORD_W-1:0] = acc.pre_data;
                    if (acc.pre_other == PO_CLEAR) begin
                        nxt_s.value[ACC_W-1:UPPER_LSB] = '0;
                    end else if (acc.pre_other == PO_SIGNEXT) begin
                        nxt_s.value[ACC_W-1:UPPER_LSB] = {ext8, ext16};
                    end
                end
                PF_UPPER: begin
                    nxt_s.value[GUARD_LSB-1:UPPER_LSB] = acc.pre_data;
                    if (acc.pre_other == PO_CLEAR) begin
                        nxt_s.value[ACC_W-1:GUARD_LSB] = '0;
                        nxt_s.value[WORD_W-1:0]        = '0;
                    end else if (acc.pre_other == PO_SIGNEXT) begin
                        nxt_s.value[ACC_W-1:GUARD_LSB] = ext8;
                        nxt_s.value[WORD_W-1:0]        = '0;
                    end
                end
                default: begin
                    // bits below the loaded guard byte cannot carry its sign, so they clear unless PO_KEEP keeps them
                    nxt_s.value[ACC_W-1:GUARD_LSB] = acc.pre_data[GUARD_W-1:0];
                    if (acc.pre_other != PO_KEEP) begin
                        nxt_s.value[GUARD_LSB-1:0] = '0;
                    end
                end
            endcase
            nxt_s.tag = acc.pre_signed;
        end else if (acc.wr) begin
            // RQ22: load from the adder/subtracter
            nxt_s.value = acc.sum;
            nxt_s.tag   = acc.sum_signed;
        end
    end

    // RQ26: capture at the closing rising edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_ff <= '{value: ACC_RST, tag: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign acc.value = s_ff.value;
    assign acc.tag   = s_ff.tag;

    acc_sum_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ26
        acc.wr && !acc.pre_en |=> acc.value == $past(acc.sum) && acc.tag == $past(acc.sum_signed))
        else $error("accumulator missed the adder result");
    acc_lower_preload_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ25
        acc.pre_en && acc.pre_field == PF_LOWER && acc.pre_other == PO_CLEAR
        |=> acc.value == {24'h0, $past(acc.pre_data)})
        else $error("lower preload with clear went wrong");
endmodule : imac_acc

// ==== src/imac_acc_if.sv ====
`timescale 1ns/1ps
interface imac_acc_if;
    import imac_pkg::*;
    logic [ACC_W-1:0]  sum;
    logic              sum_signed;
    logic              wr;
    logic              pre_en;
    logic [1:0]        pre_field;
    logic [1:0]        pre_other;
    logic              pre_signed;
    logic [WORD_W-1:0] pre_data;
    logic [ACC_W-1:0]  value;
    logic              tag;
    modport ctrl  (output sum, sum_signed, wr, pre_en, pre_field, pre_other, pre_signed, pre_data,
                   input value, tag);
    modport store (input sum, sum_signed, wr, pre_en, pre_field, pre_other, pre_signed, pre_data,
                   output value, tag);
endinterface : imac_acc_if

// ==== src/imac_datapath.sv ====
`timescale 1ns/1ps
// How it works
// RQ1: multiplier takes 16-bit twos-complement, unsigned or mixed operands.
// RQ2: operand format slice applies at multiplier inputs, not at buffer loading.
// RQ3: every result carries a signed/unsigned tag, visible on status outputs.
// RQ4: result signed if any term signed; unsigned only for logic or all-unsigned multiplies. The code also tags a pass of an unsigned accumulator unsigned.
// RQ5: feedback codes 0-3 pick accumulator A, B or flag-conditioned choice unshifted.
// RQ6: codes 4-7 pick A or B, shifted left or right when flag set.
// RQ7: every accumulator reference uses this instruction's feedback choice.
// RQ8: left feedback shift inserts zero at bit 0.
// RQ9: right feedback shift fills bit 39 with sign for signed, else zero.
// RQ10: all operations start at rising edge and finish within one period.
// RQ11: three-bit class slice separates multiplication and non-multiplication instructions.
// RQ12: class value 111 means non-multiplication; anything else multiplies.
// RQ13: logic unit combines both Y holds and feeds the second multiplier input.
// RQ14: 16-bit first and second operands give a 32-bit product.
// RQ15: one 16-bit status word per accumulator holds format information.
// RQ16: multiplications may round unbiased at sum bit 16, 15 or 14, or not.
// RQ17: rounding adds one with carry; exact mid-scale rounds to even.
// RQ18: format adjust shifts the 32-bit product left one, logically.
// RQ19: product extends to 40 bits by sign when signed/mixed, else zeros.
// RQ20: adder combines product and accumulator; 40-bit sum writes accumulators and output.
// RQ21: sum bits 31..16 can load either or both Y holds.
// RQ22: each accumulator loads from the sum or from preload port data.
// RQ23: accumulators split into lower word, upper word and guard byte 39..32.
// RQ24: guard byte allows at least 256 accumulations without true data loss.
// RQ25: preload fills one field; others cleared, sign-extended or kept.
// RQ26: accumulators capture sum and tag at the rising edge ending the cycle.
module imac_datapath
    import imac_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic [AL_W-1:0]   i_arith_logic_field,
    input  wire logic [2:0]        i_feedback_select_field,
    input  wire logic              i_condition_flag,
    input  wire logic              i_format_adjust,
    input  wire logic [WORD_W-1:0] i_mult_first_input,
    input  wire logic [WORD_W-1:0] i_y_data,
    input  wire logic [1:0]        i_my_sel,
    input  wire logic [1:0]        i_logic_op,
    input  wire logic [1:0]        i_y0_src,
    input  wire logic [1:0]        i_y1_src,
    input  wire logic [1:0]        i_acc_wr,
    input  wire logic [1:0]        i_pre_en,
    input  wire logic [1:0][1:0]   i_pre_field,
    input  wire logic [1:0][1:0]   i_pre_other,
    input  wire logic [1:0]        i_pre_signed,
    output logic      [ACC_W-1:0]  o_sum_bus,
    output logic                   o_sum_signed,
    output logic      [ACC_W-1:0]  o_accumulator_a,
    output logic      [ACC_W-1:0]  o_accumulator_b,
    output logic      [WORD_W-1:0] o_y_hold_zero,
    output logic      [WORD_W-1:0] o_y_hold_one,
    output logic      [WORD_W-1:0] o_status_a,
    output logic      [WORD_W-1:0] o_status_b
);
    imac_core_t s_ff;
    imac_core_t nxt_s;

    logic [1:0][ACC_W-1:0] acc_val;
    logic [1:0]            acc_tag;
    logic [1:0][WORD_W-1:0] status;

    logic [2:0]         cls;
    logic [2:0]         nop;
    logic [1:0]         fmt;
    logic [1:0]         rnd;
    logic               nonmult;
    imac_feed_t         feed;
    logic               use_b;
    logic               shl;
    logic               shr;
    logic [ACC_W-1:0]   fb_src;
    logic               fb_tag;
    logic [ACC_W-1:0]   fb_val;
    logic [WORD_W-1:0]  lu;
    logic [WORD_W-1:0]  my;
    logic               xs;
    logic               ys;
    logic signed [16:0] xe;
    logic signed [16:0] ye;
    logic signed [33:0] prod_full;
    logic [PROD_W-1:0]  product_bus;
    logic               prod_signed;
    logic [ACC_W-1:0]   prod_ext;
    logic [ACC_W-1:0]   mz_word;
    logic [ACC_W-1:0]   raw;
    logic               tag;
    logic [ACC_W-1:0]   sum;

    function automatic logic [ACC_W-1:0] round_even(input logic [ACC_W-1:0] v, input logic [5:0] pos);
        logic [ACC_W-1:0] one;
        logic [ACC_W-1:0] r;
        one = ACC_W'(40'h1) << pos;
        r   = v + one;
        // exact mid-scale: force the retained lsb to zero
        if (v[pos] && ((v & (one - 40'h1)) == '0)) begin
            r[pos + 6'h01] = 1'b0;
        end
        return r;
    endfunction : round_even

    function automatic logic [WORD_W-1:0] ysrc_pick(input logic [1:0] sel, input logic [WORD_W-1:0] held,
                                                    input logic [WORD_W-1:0] port,
                                                    input logic [WORD_W-1:0] upper);
        logic [WORD_W-1:0] r;
        r = held;
        if (sel == YSRC_PORT) begin
            r = port;
        end else if (sel == YSRC_SUM) begin
            r = upper;
        end
        return r;
    endfunction : ysrc_pick

    always_comb begin
        nxt_s   = s_ff;
        // RQ11: instruction class slice
        cls     = i_arith_logic_field[AL_CLS_LSB +: 3];
        // RQ12: 111 is the non-multiplication class
        nonmult = (cls == CLS_NONMULT);
        nop     = i_arith_logic_field[AL_NOP_LSB +: 3];
        fmt     = i_arith_logic_field[AL_FMT_LSB +: 2];
        rnd     = i_arith_logic_field[AL_RND_LSB +: 2];
        feed    = imac_feed_t'(i_feedback_select_field);
        use_b   = 1'b0;
        shl     = 1'b0;
        shr     = 1'b0;
        // RQ5: accumulator pick, conditional codes included
        // RQ6: flag-conditioned shift codes
        unique case (feed)
            FEED_FIRST_ACC:              use_b = 1'b0;
            FEED_SECOND_ACC:             use_b = 1'b1;
            FEED_COND_FIRST_ELSE_SECOND: use_b = !i_condition_flag;
            FEED_COND_SECOND_ELSE_FIRST: use_b = i_condition_flag;
            FEED_FIRST_COND_LEFT:        shl   = i_condition_flag;
            FEED_SECOND_COND_LEFT: begin
                use_b = 1'b1;
                shl   = i_condition_flag;
            end
            FEED_FIRST_COND_RIGHT:       shr   = i_condition_flag;
            FEED_SECOND_COND_RIGHT: begin
                use_b = 1'b1;
                shr   = i_condition_flag;
            end
        endcase
        // RQ7: one feedback value serves every accumulator term
        fb_src = acc_val[use_b];
        fb_tag = acc_tag[use_b];
        fb_val = fb_src;
        if (shl) begin
            // RQ8: logical left, zero in
            fb_val = {fb_src[ACC_W-2:0], 1'b0};
        end else if (shr) begin
            // RQ9: arithmetic right follows the content tag
            fb_val = {fb_tag & fb_src[ACC_W-1], fb_src[ACC_W-1:1]};
        end
        // RQ13: logic unit on both Y holds
        unique case (i_logic_op)
            LU_AND:  lu = s_ff.y0 & s_ff.y1;
            LU_OR:   lu = s_ff.y0 | s_ff.y1;
            LU_XOR:  lu = s_ff.y0 ^ s_ff.y1;
            default: lu = ~s_ff.y1;
        endcase
        unique case (i_my_sel)
            MY_Y0:    my = s_ff.y0;
            MY_Y1:    my = s_ff.y1;
            MY_LOGIC: my = lu;
            default:  my = i_y_data;
        endcase
        // RQ1: per-operand signedness
        // RQ2: format applied only here at the multiplier
        xs          = fmt[FMT_X_SIGNED_BIT];
        ys          = fmt[FMT_Y_SIGNED_BIT];
        xe          = $signed({xs & i_mult_first_input[WORD_W-1], i_mult_first_input});
        ye          = $signed({ys & my[WORD_W-1], my});
        // RQ14: 16 by 16 gives 32 bits
        prod_full   = xe * ye;
        product_bus = prod_full[PROD_W-1:0];
        prod_signed = xs | ys;
        // RQ18: format adjust, logical left
        if (i_format_adjust) begin
            product_bus = {product_bus[PROD_W-2:0], 1'b0};
        end
        // RQ24: eight guard bits take the carries of long sums
        // RQ19: widen by format
        prod_ext = prod_signed ? {{GUARD_W{product_bus[PROD_W-1]}}, product_bus}
                               : {{GUARD_W{1'b0}}, product_bus};
        mz_word  = {{GUARD_W{my[WORD_W-1]}}, my, WORD_RST};
        raw      = fb_val;
        tag      = 1'b1;
        // RQ20: add/subtract product and feedback
        // RQ4: tag follows term signedness for product, accumulate-plus and pass; logic is unsigned, all other operations signed
        if (!nonmult) begin
            unique case (cls)
                MOP_PROD: begin
                    raw = prod_ext;
                    tag = prod_signed;
                end
                MOP_ACC_PLUS: begin
                    raw = fb_val + prod_ext;
                    tag = prod_signed | fb_tag;
                end
                MOP_ACC_MINUS: raw = fb_val - prod_ext;
                MOP_NEG_PROD:  raw = ACC_RST - prod_ext;
                default:       raw = prod_ext - fb_val;
            endcase
        end else begin
            unique case (nop)
                NOP_ADD: raw = fb_val + mz_word;
                NOP_SUB: raw = fb_val - mz_word;
                NOP_NEG: raw = ACC_RST - fb_val;
                NOP_LOGIC: begin
                    raw = {{GUARD_W{1'b0}}, lu, WORD_RST};
                    tag = 1'b0;
                end
                default: tag = fb_tag;
            endcase
        end
        // RQ16: rounding position for multiplications
        // RQ17: unbiased, ties to even
        sum = raw;
        if (!nonmult) begin
            unique case (rnd)
                RND_AT16: sum = round_even(raw, RND_POS16);
                RND_AT15: sum = round_even(raw, RND_POS15);
                RND_AT14: sum = round_even(raw, RND_POS14);
                default:  sum = raw;
            endcase
        end
        // RQ21: upper word of the sum into the Y holds
        nxt_s.y0      = ysrc_pick(i_y0_src, s_ff.y0, i_y_data, sum[GUARD_LSB-1:UPPER_LSB]);
        nxt_s.y1      = ysrc_pick(i_y1_src, s_ff.y1, i_y_data, sum[GUARD_LSB-1:UPPER_LSB]);
        nxt_s.sum_tag = tag;
    end

    // RQ10: single-cycle path, state moves on the rising edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_ff <= '{y0: WORD_RST, y1: WORD_RST, sum_tag: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    imac_acc_if acc_bus [2] ();

    // RQ22: both accumulators see the same sum and port data
    // RQ15: one status word per accumulator
    for (genvar g = 0; g < 2; g++) begin : g_acc
        assign acc_bus[g].sum        = sum;
        assign acc_bus[g].sum_signed = tag;
        assign acc_bus[g].wr         = i_acc_wr[g];
        assign acc_bus[g].pre_en     = i_pre_en[g];
        assign acc_bus[g].pre_field  = i_pre_field[g];
        assign acc_bus[g].pre_other  = i_pre_other[g];
        assign acc_bus[g].pre_signed = i_pre_signed[g];
        assign acc_bus[g].pre_data   = i_y_data;
        assign acc_val[g]            = acc_bus[g].value;
        assign acc_tag[g]            = acc_bus[g].tag;
        // RQ3: flags for accumulator contents and latest sum
        always_comb begin
            status[g]                 = WORD_RST;
            status[g][ST_ACC_TAG_BIT] = acc_tag[g];
            status[g][ST_SUM_TAG_BIT] = s_ff.sum_tag;
        end
        imac_acc u_acc (
            .i_clk   (i_clk),
            .i_rst_n (i_rst_n),
            .acc     (acc_bus[g])
        );
    end

    // sum leaves combinationally so the output shifter sees it in the same cycle
    assign o_sum_bus       = sum;
    assign o_sum_signed    = tag;
    assign o_accumulator_a = acc_val[0];
    assign o_accumulator_b = acc_val[1];
    assign o_y_hold_zero   = s_ff.y0;
    assign o_y_hold_one    = s_ff.y1;
    assign o_status_a      = status[0];
    assign o_status_b      = status[1];

    feed_pick_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ5
        i_feedback_select_field == FEED_COND_FIRST_ELSE_SECOND
        |-> fb_val == (i_condition_flag ? acc_val[0] : acc_val[1]))
        else $error("conditional feedback picked the wrong accumulator");
    left_shift_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ8
        i_feedback_select_field == FEED_FIRST_COND_LEFT && i_condition_flag
        |-> fb_val == {acc_val[0][ACC_W-2:0], 1'b0})
        else $error("left feedback shift wrong");
    right_shift_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ9
        i_feedback_select_field == FEED_SECOND_COND_RIGHT && i_condition_flag
        |-> fb_val == {acc_tag[1] & acc_val[1][ACC_W-1], acc_val[1][ACC_W-1:1]})
        else $error("right feedback shift wrong");
    unsigned_tag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ4
        cls == MOP_PROD && fmt == 2'h0 |-> !o_sum_signed)
        else $error("all-unsigned product tagged signed");
    signed_tag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ4
        !nonmult && fmt != 2'h0 |-> o_sum_signed)
        else $error("signed operand gave unsigned tag");
    logic_path_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ13
        nonmult && nop == NOP_LOGIC && i_logic_op == LU_XOR
        |-> o_sum_bus[GUARD_LSB-1:UPPER_LSB] == (o_y_hold_zero ^ o_y_hold_one) && !o_sum_signed)
        else $error("logic result or tag wrong");
    y_hold_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ21
        i_y0_src == YSRC_SUM |=> o_y_hold_zero == $past(o_sum_bus[GUARD_LSB-1:UPPER_LSB]))
        else $error("Y hold missed the sum upper word");
    round_even_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ17
        !nonmult && rnd == RND_AT15 && raw[15:0] == 16'h8000 |-> !o_sum_bus[16] && o_sum_bus[15:0] == 16'h0)
        else $error("mid-scale did not round to even");
    status_tag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RQ3
        1'b1 |=> o_status_a[ST_SUM_TAG_BIT] == $past(o_sum_signed))
        else $error("status does not show the last sum format");
endmodule : imac_datapath

// ==== src/imac_pkg.sv ====
package imac_pkg;
    localparam int ACC_W     = 40;
    localparam int WORD_W    = 16;
    localparam int PROD_W    = 32;
    localparam int GUARD_W   = 8;
    localparam int UPPER_LSB = 16;
    localparam int GUARD_LSB = 32;
    localparam int AL_W      = 8;
    // slices of the arithmetic control field, counted from its bit 0
    localparam int AL_CLS_LSB = 0;
    localparam int AL_RND_LSB = 3;
    localparam int AL_NOP_LSB = 5;
    localparam int AL_FMT_LSB = 6;
    localparam logic [2:0] CLS_NONMULT = 3'h7;
    // multiplication operations
    localparam logic [2:0] MOP_PROD       = 3'h0;
    localparam logic [2:0] MOP_ACC_PLUS   = 3'h1;
    localparam logic [2:0] MOP_ACC_MINUS  = 3'h2;
    localparam logic [2:0] MOP_NEG_PROD   = 3'h3;
    // non-multiplication operations
    localparam logic [2:0] NOP_ADD   = 3'h0;
    localparam logic [2:0] NOP_SUB   = 3'h1;
    localparam logic [2:0] NOP_PASS  = 3'h2;
    localparam logic [2:0] NOP_NEG   = 3'h3;
    localparam logic [2:0] NOP_LOGIC = 3'h7;
    // operand format bits
    localparam int FMT_X_SIGNED_BIT = 1;
    localparam int FMT_Y_SIGNED_BIT = 0;
    // rounding
    localparam logic [1:0] RND_NONE = 2'h0;
    localparam logic [1:0] RND_AT16 = 2'h1;
    localparam logic [1:0] RND_AT15 = 2'h2;
    localparam logic [1:0] RND_AT14 = 2'h3;
    localparam logic [5:0] RND_POS16 = 6'h10;
    localparam logic [5:0] RND_POS15 = 6'h0f;
    localparam logic [5:0] RND_POS14 = 6'h0e;
    typedef enum logic [2:0] {
        FEED_FIRST_ACC              = 3'h0,
        FEED_SECOND_ACC             = 3'h1,
        FEED_COND_FIRST_ELSE_SECOND = 3'h2,
        FEED_COND_SECOND_ELSE_FIRST = 3'h3,
        FEED_FIRST_COND_LEFT        = 3'h4,
        FEED_SECOND_COND_LEFT       = 3'h5,
        FEED_FIRST_COND_RIGHT       = 3'h6,
        FEED_SECOND_COND_RIGHT      = 3'h7
    } imac_feed_t;
    localparam logic [1:0] LU_AND    = 2'h0;
    localparam logic [1:0] LU_OR     = 2'h1;
    localparam logic [1:0] LU_XOR    = 2'h2;
    localparam logic [1:0] LU_NOT_Y1 = 2'h3;
    localparam logic [1:0] MY_Y0    = 2'h0;
    localparam logic [1:0] MY_Y1    = 2'h1;
    localparam logic [1:0] MY_LOGIC = 2'h2;
    localparam logic [1:0] MY_PORT  = 2'h3;
    localparam logic [1:0] YSRC_HOLD = 2'h0;
    localparam logic [1:0] YSRC_PORT = 2'h1;
    localparam logic [1:0] YSRC_SUM  = 2'h2;
    localparam logic [1:0] PF_LOWER = 2'h0;
    localparam logic [1:0] PF_UPPER = 2'h1;
    localparam logic [1:0] PF_GUARD = 2'h2;
    localparam logic [1:0] PO_KEEP    = 2'h0;
    localparam logic [1:0] PO_CLEAR   = 2'h1;
    localparam logic [1:0] PO_SIGNEXT = 2'h2;
    localparam int ST_ACC_TAG_BIT = 0;
    localparam int ST_SUM_TAG_BIT = 1;
    localparam logic [ACC_W-1:0]  ACC_RST  = 40'h0;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0;
    typedef struct packed {
        logic [ACC_W-1:0] value;
        logic             tag;
    } imac_acc_t;
    typedef struct packed {
        logic [WORD_W-1:0] y0;
        logic [WORD_W-1:0] y1;
        logic              sum_tag;
    } imac_core_t;
endpackage : imac_pkg

// ==== testbench/imac_seq.sv ====
`timescale 1ns/1ps
module imac_seq
    import imac_pkg::*;
(
    input  wire logic              i_clk,
    output logic      [AL_W-1:0]   o_field,
    output logic      [2:0]        o_fb,
    output logic                   o_flag,
    output logic                   o_adj,
    output logic      [WORD_W-1:0] o_x,
    output logic      [WORD_W-1:0] o_y,
    output logic      [1:0]        o_wr,
    output logic      [1:0]        o_pre,
    output logic      [1:0]        o_ysrc
);
    initial {o_field, o_fb, o_flag, o_adj, o_x, o_y, o_wr, o_pre, o_ysrc} = '0;
    task automatic issue(input logic [AL_W-1:0] f, input logic [2:0] fb, input logic fl, input logic aj,
                         input logic [WORD_W-1:0] xv, input logic [WORD_W-1:0] yv, input logic [1:0] w,
                         input logic [1:0] p, input logic [1:0] ys);
        // one instruction per cycle, held until the next one replaces it
        @(negedge i_clk);
        {o_field, o_fb, o_flag, o_adj, o_x, o_y, o_wr, o_pre, o_ysrc} = {f, fb, fl, aj, xv, yv, w, p, ys};
        #1;
    endtask : issue
endmodule : imac_seq

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import imac_pkg::*;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [AL_W-1:0]   field;
    logic [2:0]        fb;
    logic              flag, adj, sum_sg;
    logic [WORD_W-1:0] x, y, y0, y1, st_a, st_b;
    logic [1:0]        wr, pre, ysrc;
    logic [ACC_W-1:0]  sum, acc_a, acc_b;
    int                num_errors = 0;
    int                cmp_count = 0;
    always #20 clk = ~clk;
    imac_seq i_seq (.i_clk(clk), .o_field(field), .o_fb(fb), .o_flag(flag), .o_adj(adj), .o_x(x), .o_y(y),
                    .o_wr(wr), .o_pre(pre), .o_ysrc(ysrc));
    imac_datapath i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_arith_logic_field(field), .i_feedback_select_field(fb),
        .i_condition_flag(flag), .i_format_adjust(adj), .i_mult_first_input(x), .i_y_data(y),
        .i_my_sel(MY_PORT), .i_logic_op(LU_XOR), .i_y0_src(ysrc), .i_y1_src(YSRC_PORT), .i_acc_wr(wr),
        .i_pre_en(pre), .i_pre_field(4'h0), .i_pre_other(4'h5), .i_pre_signed(pre), .o_sum_bus(sum),
        .o_sum_signed(sum_sg), .o_accumulator_a(acc_a), .o_accumulator_b(acc_b), .o_y_hold_zero(y0),
        .o_y_hold_one(y1), .o_status_a(st_a), .o_status_b(st_b));
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [ACC_W:0] got, input logic [ACC_W:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // sum and its tag are combinational, so they are looked at inside the cycle
    task automatic op(input string n, input logic [AL_W-1:0] f, input logic [2:0] c, input logic fl,
                      input logic aj, input logic [15:0] xv, input logic [15:0] yv, input logic [1:0] w,
                      input logic [1:0] p, input logic et, input logic [ACC_W-1:0] es);
        i_seq.issue(f, c, fl, aj, xv, yv, w, p, YSRC_SUM);
        chk({sum_sg, sum}, {et, es}, n);
        @(posedge clk);
        #1;
        $display("test %s done", n);
    endtask : op
    initial begin
        #20000;
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        chk({1'b0, acc_a}, '0, "reset acc");
        op("mac", 8'h01, FEED_FIRST_ACC, 0, 0, 16'h2, 16'h3, 2'h1, 2'h0, 0, 40'h6);
        chk({1'b0, acc_a}, {1'b0, 40'h6}, "acc a");
        op("mixed", 8'h81, FEED_FIRST_ACC, 0, 0, 16'hffff, 16'h9, 2'h1, 2'h0, 1, 40'hfffffffffd);
        chk({25'h0, st_a}, {25'h0, 16'h3}, "status a");
        op("preload", 8'h47, FEED_SECOND_ACC, 0, 0, 16'h0, 16'h8000, 2'h0, 2'h2, 0, 40'h0);
        chk({1'b0, acc_b}, {1'b0, 40'h8000}, "acc b");
        chk({25'h0, y1}, {25'h0, 16'h8000}, "y hold one");
        chk({25'h0, st_b}, {25'h0, 16'h1}, "status b");
        op("left", 8'h01, FEED_SECOND_COND_LEFT, 1, 0, 16'h0, 16'h0, 2'h0, 2'h0, 1, 40'h10000);
        op("right", 8'h01, FEED_FIRST_COND_RIGHT, 1, 0, 16'h0, 16'h0, 2'h0, 2'h0, 1, 40'hfffffffffe);
        op("noshift", 8'h01, FEED_FIRST_COND_RIGHT, 0, 0, 16'h0, 16'h0, 2'h0, 2'h0, 1, 40'hfffffffffd);
        op("left_a", 8'h01, FEED_FIRST_COND_LEFT, 1, 0, 16'h0, 16'h0, 2'h0, 2'h0, 1, 40'hfffffffffa);
        op("right_b", 8'h01, FEED_SECOND_COND_RIGHT, 1, 0, 16'h0, 16'h0, 2'h0, 2'h0, 1, 40'h4000);
        op("cond_b", 8'h01, FEED_COND_FIRST_ELSE_SECOND, 0, 0, 16'h0, 16'h0, 2'h0, 2'h0, 1, 40'h8000);
        op("cond_a", 8'h01, FEED_COND_SECOND_ELSE_FIRST, 0, 0, 16'h0, 16'h0, 2'h0, 2'h0, 1, 40'hfffffffffd);
        op("adjust", 8'h00, FEED_FIRST_ACC, 0, 1, 16'h3, 16'h5, 2'h0, 2'h0, 0, 40'h1e);
        op("round16", 8'h08, FEED_FIRST_ACC, 0, 0, 16'h3, 16'h8000, 2'h0, 2'h0, 0, 40'h28000);
        op("round14", 8'h18, FEED_FIRST_ACC, 0, 0, 16'h1, 16'h4000, 2'h0, 2'h0, 0, 40'h0);
        op("round_mid", 8'h10, FEED_FIRST_ACC, 0, 0, 16'h1, 16'h8000, 2'h0, 2'h0, 0, 40'h0);
        op("round_even", 8'h10, FEED_FIRST_ACC, 0, 0, 16'h3, 16'h8000, 2'h0, 2'h0, 0, 40'h20000);
        chk({25'h0, y0}, {25'h0, 16'h2}, "y hold zero");
        op("negate", 8'h03, FEED_FIRST_ACC, 0, 0, 16'h2, 16'h3, 2'h0, 2'h0, 1, 40'hfffffffffa);
        op("logic", 8'he7, FEED_FIRST_ACC, 0, 0, 16'h0, 16'h0, 2'h0, 2'h0, 0, 40'hfffc0000);
        stop_test();
    end
endmodule : tb_top
